//--- pmrh_pkg.sv
// package: constants and state types for the position monitor and reference handshake
package pmrh_pkg;
  localparam int unsigned PMRH_POS_W = 32;
  localparam int unsigned PMRH_TIME_W = 16;
  localparam int unsigned PMRH_CAM_N = 2;
  // clock and time base
  localparam int unsigned PMRH_CLK_PERIOD_NS = 10;
  localparam int unsigned PMRH_TIME_UNIT_NS = 1000000;
  localparam int unsigned PMRH_TICK_CYCLES = PMRH_TIME_UNIT_NS / PMRH_CLK_PERIOD_NS;
  // values after reset
  localparam logic PMRH_RST_FLAG = 1'h0;
  localparam logic PMRH_RST_NO_FE = 1'h1;
  localparam logic [PMRH_TIME_W-1:0] PMRH_RST_TIMER = 16'h0000;
  localparam logic [PMRH_POS_W-1:0] PMRH_RST_VALUE = 32'h00000000;
  typedef enum logic [2:0] {
    PMRH_IDLE,
    PMRH_RUN_SEARCH,
    PMRH_RUN_PROBE,
    PMRH_CONFLICT,
    PMRH_WAIT_RELEASE
  } pmrh_ref_state_e;
endpackage : pmrh_pkg

//--- pmrh_cam.sv
// one cam comparator: flag set while actual position is at or below the cam position
`timescale 1ns/1ps
`default_nettype none
module pmrh_cam #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // positions
  input wire logic signed [W-1:0] i_position_actual,
  input wire logic signed [W-1:0] i_cam_position,
  // flag
  output logic o_cam_flag
);
  import pmrh_pkg::*;
  wire logic at_or_below;
  assign at_or_below = (i_position_actual <= i_cam_position);
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_cam_flag <= PMRH_RST_FLAG;
    end else begin
      o_cam_flag <= at_or_below;
    end
  end
endmodule : pmrh_cam
`default_nettype wire

//--- pmrh_top.sv
// top: position supervision, cam comparators and reference/probe handshake
// Summary of operation
// - Standstill fault if error outside window after standstill time while setpoint static.
// - Positioning supervision armed only when static, no traverse, window nonzero.
// - After positioning time, window checked exactly once; outside raises positioning fault.
// - Zero standstill or positioning window disables that supervision.
// - Following error magnitude above nonzero tolerance raises fault and clears no-error flag.
// - Two cam flags, set while position at or below cam, else cleared.
// - Search or probe starts only on rising request edge, sent via control word.
// - Probe capture uses probe select and edge select inputs.
// - Function active follows encoder status; valid set when value captured.
// - Active, valid and value held after completion until request drops.
// - Request withdrawn early aborts via control word; active follows status.
// - Both requests set aborts, starts nothing, alarm held until both released.
// - Encoder fault during an active function raises the abort alarm.
// - Encoder control outputs and request history are zero after reset.
`timescale 1ns/1ps
`default_nettype none
module pmrh_top #(
  parameter int unsigned P_POS_W = pmrh_pkg::PMRH_POS_W,
  parameter int unsigned P_TIME_W = pmrh_pkg::PMRH_TIME_W,
  parameter int unsigned P_TICK_CYCLES = pmrh_pkg::PMRH_TICK_CYCLES
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // supervision configuration
  input wire logic [P_POS_W-1:0] I_STANDSTILL_WINDOW,
  input wire logic [P_TIME_W-1:0] I_STANDSTILL_TIME,
  input wire logic [P_POS_W-1:0] I_POSITIONING_WINDOW,
  input wire logic [P_TIME_W-1:0] I_POSITIONING_TIME,
  input wire logic [P_POS_W-1:0] I_FOLLOWING_ERROR_TOLERANCE,
  input wire logic signed [P_POS_W-1:0] I_CAM_POSITION_ONE,
  input wire logic signed [P_POS_W-1:0] I_CAM_POSITION_TWO,
  // controller state
  input wire logic I_SETPOINT_STATIC,
  input wire logic I_TRAVERSE_CMD_ACTIVE,
  input wire logic signed [P_POS_W-1:0] I_POSITION_ERROR,
  input wire logic signed [P_POS_W-1:0] I_FOLLOWING_ERROR_VALUE,
  input wire logic signed [P_POS_W-1:0] I_POSITION_ACTUAL,
  input wire logic I_FAULT_ACK,
  // supervision outputs
  output logic O_STANDSTILL_FAULT,
  output logic O_POSITIONING_FAULT,
  output logic O_FOLLOWING_ERROR_FAULT,
  output logic O_NO_FOLLOWING_ERROR_FLAG,
  output logic O_CAM_FLAG_ONE,
  output logic O_CAM_FLAG_TWO,
  // reference requests
  input wire logic I_REF_MARK_SEARCH_REQ,
  input wire logic I_PROBE_EVAL_REQ,
  input wire logic I_PROBE_SELECT,
  input wire logic I_PROBE_EDGE_SELECT,
  // encoder status word
  input wire logic I_ENC_STAT_FUNC_ACTIVE,
  input wire logic I_ENC_STAT_VALUE_VALID,
  input wire logic I_ENC_STAT_FAULT,
  input wire logic signed [P_POS_W-1:0] I_ENC_MEASURED,
  // encoder control word
  output logic O_ENC_CTRL_REF_SEARCH,
  output logic O_ENC_CTRL_PROBE_EVAL,
  output logic O_ENC_CTRL_PROBE_SEL,
  output logic O_ENC_CTRL_PROBE_EDGE,
  // reference status
  output logic O_REF_FUNCTION_ACTIVE,
  output logic O_MEASURED_VALUE_VALID,
  output logic signed [P_POS_W-1:0] O_MEASURED_VALUE,
  output logic O_REF_FUNCTION_ABORT_ALARM
);
  import pmrh_pkg::*;

  function automatic logic [P_POS_W-1:0] abs_of(input logic signed [P_POS_W-1:0] v);
    abs_of = v[P_POS_W-1] ? P_POS_W'(-v) : P_POS_W'(v);
  endfunction : abs_of

  // time base tick, one per time unit
  logic [31:0] tick_cnt;
  wire logic tick;
  assign tick = (tick_cnt == 32'(P_TICK_CYCLES - 1));
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN || tick) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // standstill supervision
  logic [P_TIME_W-1:0] ss_cnt;
  wire logic ss_armed;
  wire logic ss_elapsed;
  wire logic ss_outside;
  wire logic ss_set;
  assign ss_armed = I_SETPOINT_STATIC && (I_STANDSTILL_WINDOW != '0);
  assign ss_elapsed = (ss_cnt >= I_STANDSTILL_TIME);
  assign ss_outside = (abs_of(I_POSITION_ERROR) > I_STANDSTILL_WINDOW);
  assign ss_set = ss_armed && ss_elapsed && ss_outside;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN || !ss_armed) begin
      ss_cnt <= P_TIME_W'(PMRH_RST_TIMER);
    end else if (tick && !ss_elapsed) begin
      ss_cnt <= ss_cnt + P_TIME_W'(1'h1);
    end
  end

  // positioning supervision, checked a single time
  logic [P_TIME_W-1:0] pos_cnt;
  logic pos_done;
  wire logic pos_armed;
  wire logic pos_check;
  wire logic pos_set;
  assign pos_armed = I_SETPOINT_STATIC && !I_TRAVERSE_CMD_ACTIVE
                     && (I_POSITIONING_WINDOW != '0);
  assign pos_check = pos_armed && !pos_done && (pos_cnt >= I_POSITIONING_TIME);
  assign pos_set = pos_check && (abs_of(I_POSITION_ERROR) > I_POSITIONING_WINDOW);
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN || !pos_armed) begin
      pos_cnt <= P_TIME_W'(PMRH_RST_TIMER);
      pos_done <= PMRH_RST_FLAG;
    end else begin
      if (tick && (pos_cnt < I_POSITIONING_TIME)) begin
        pos_cnt <= pos_cnt + P_TIME_W'(1'h1);
      end
      if (pos_check) begin
        pos_done <= 1'h1;
      end
    end
  end

  // following error supervision
  wire logic fe_over;
  assign fe_over = (I_FOLLOWING_ERROR_TOLERANCE != '0)
                   && (abs_of(I_FOLLOWING_ERROR_VALUE) > I_FOLLOWING_ERROR_TOLERANCE);

  // fault latches, a new event wins over the acknowledge
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_STANDSTILL_FAULT <= PMRH_RST_FLAG;
      O_POSITIONING_FAULT <= PMRH_RST_FLAG;
      O_FOLLOWING_ERROR_FAULT <= PMRH_RST_FLAG;
      O_NO_FOLLOWING_ERROR_FLAG <= PMRH_RST_NO_FE;
    end else begin
      O_STANDSTILL_FAULT <= ss_set || (O_STANDSTILL_FAULT && !I_FAULT_ACK);
      O_POSITIONING_FAULT <= pos_set || (O_POSITIONING_FAULT && !I_FAULT_ACK);
      O_FOLLOWING_ERROR_FAULT <= fe_over || (O_FOLLOWING_ERROR_FAULT && !I_FAULT_ACK);
      O_NO_FOLLOWING_ERROR_FLAG <= !fe_over;
    end
  end

  // cam comparators
  wire logic signed [P_POS_W-1:0] cam_pos [PMRH_CAM_N];
  wire logic [PMRH_CAM_N-1:0] cam_flag;
  assign cam_pos[0] = I_CAM_POSITION_ONE;
  assign cam_pos[1] = I_CAM_POSITION_TWO;
  for (genvar g = 0; g < PMRH_CAM_N; g++) begin : gen_cam
    pmrh_cam #(.W(P_POS_W)) u_cam (
      .i_clk(I_REF_CLK),
      .i_rstn(I_RSTN),
      .i_position_actual(I_POSITION_ACTUAL),
      .i_cam_position(cam_pos[g]),
      .o_cam_flag(cam_flag[g])
    );
  end
  assign O_CAM_FLAG_ONE = cam_flag[0];
  assign O_CAM_FLAG_TWO = cam_flag[1];

  // reference search / probe handshake
  pmrh_ref_state_e state;
  pmrh_ref_state_e next_state;
  logic ref_req_prev;
  logic probe_req_prev;
  logic captured;
  wire logic both_req;
  wire logic rise_ref;
  wire logic rise_probe;
  wire logic running;
  wire logic run_req;
  wire logic enc_fault_run;
  assign both_req = I_REF_MARK_SEARCH_REQ && I_PROBE_EVAL_REQ;
  assign rise_ref = I_REF_MARK_SEARCH_REQ && !ref_req_prev;
  assign rise_probe = I_PROBE_EVAL_REQ && !probe_req_prev;
  assign running = (state == PMRH_RUN_SEARCH) || (state == PMRH_RUN_PROBE);
  assign run_req = (state == PMRH_RUN_SEARCH) ? I_REF_MARK_SEARCH_REQ : I_PROBE_EVAL_REQ;
  assign enc_fault_run = running && I_ENC_STAT_FAULT;

  always_comb begin
    next_state = state;
    case (state)
      PMRH_IDLE: begin
        if (both_req) begin
          next_state = PMRH_CONFLICT;
        end else if (rise_ref) begin
          next_state = PMRH_RUN_SEARCH;
        end else if (rise_probe) begin
          next_state = PMRH_RUN_PROBE;
        end
      end
      PMRH_RUN_SEARCH, PMRH_RUN_PROBE: begin
        if (both_req) begin
          next_state = PMRH_CONFLICT;
        end else if (!run_req) begin
          next_state = PMRH_IDLE;
        end else if (I_ENC_STAT_FAULT) begin
          next_state = PMRH_WAIT_RELEASE;
        end
      end
      PMRH_CONFLICT, PMRH_WAIT_RELEASE: begin
        if (!I_REF_MARK_SEARCH_REQ && !I_PROBE_EVAL_REQ) begin
          next_state = PMRH_IDLE;
        end
      end
      default: begin
        next_state = PMRH_IDLE;
      end
    endcase
  end

  wire logic next_ctrl_ref;
  wire logic next_ctrl_probe;
  wire logic next_alarm;
  wire logic capture_now;
  wire logic stay_run;
  assign next_ctrl_ref = (next_state == PMRH_RUN_SEARCH);
  assign next_ctrl_probe = (next_state == PMRH_RUN_PROBE);
  assign next_alarm = both_req || enc_fault_run
                      || (O_REF_FUNCTION_ABORT_ALARM
                          && (I_REF_MARK_SEARCH_REQ || I_PROBE_EVAL_REQ));
  // run continues next cycle: no drop, conflict or encoder fault
  assign stay_run = running && (next_state == state);
  assign capture_now = stay_run && !captured && I_ENC_STAT_VALUE_VALID;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      state <= PMRH_IDLE;
      ref_req_prev <= PMRH_RST_FLAG;
      probe_req_prev <= PMRH_RST_FLAG;
      O_ENC_CTRL_REF_SEARCH <= PMRH_RST_FLAG;
      O_ENC_CTRL_PROBE_EVAL <= PMRH_RST_FLAG;
      O_ENC_CTRL_PROBE_SEL <= PMRH_RST_FLAG;
      O_ENC_CTRL_PROBE_EDGE <= PMRH_RST_FLAG;
      O_REF_FUNCTION_ABORT_ALARM <= PMRH_RST_FLAG;
    end else begin
      state <= next_state;
      ref_req_prev <= I_REF_MARK_SEARCH_REQ;
      probe_req_prev <= I_PROBE_EVAL_REQ;
      O_ENC_CTRL_REF_SEARCH <= next_ctrl_ref;
      O_ENC_CTRL_PROBE_EVAL <= next_ctrl_probe;
      if (state == PMRH_IDLE && next_state == PMRH_RUN_PROBE) begin
        O_ENC_CTRL_PROBE_SEL <= I_PROBE_SELECT;
        O_ENC_CTRL_PROBE_EDGE <= I_PROBE_EDGE_SELECT;
      end
      O_REF_FUNCTION_ABORT_ALARM <= next_alarm;
    end
  end

  // captured value and status, held until the request drops
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      captured <= PMRH_RST_FLAG;
      O_MEASURED_VALUE <= P_POS_W'(PMRH_RST_VALUE);
      O_MEASURED_VALUE_VALID <= PMRH_RST_FLAG;
      O_REF_FUNCTION_ACTIVE <= PMRH_RST_FLAG;
    end else begin
      if (!stay_run) begin
        captured <= 1'h0;
      end else if (capture_now) begin
        captured <= 1'h1;
        O_MEASURED_VALUE <= I_ENC_MEASURED;
      end
      O_MEASURED_VALUE_VALID <= capture_now || (captured && stay_run);
      O_REF_FUNCTION_ACTIVE <= I_ENC_STAT_FUNC_ACTIVE
                               || (captured && stay_run);
    end
  end

  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  chk_standstill_raise: assert property (ss_set |=> O_STANDSTILL_FAULT)
    else $error("standstill fault not raised");
  chk_pos_disarm: assert property (!I_SETPOINT_STATIC |=> pos_cnt == '0 && !pos_done)
    else $error("positioning supervision stayed armed");
  chk_pos_once: assert property (pos_check |=> !pos_check)
    else $error("positioning window checked twice");
  chk_pos_raise: assert property (pos_set |=> O_POSITIONING_FAULT)
    else $error("positioning fault not raised");
  chk_window_zero: assert property ((I_STANDSTILL_WINDOW == '0) && !O_STANDSTILL_FAULT
                                    |=> !O_STANDSTILL_FAULT)
    else $error("standstill fault with zero window");
  chk_fe_fault: assert property (fe_over |=> O_FOLLOWING_ERROR_FAULT
                                 && !O_NO_FOLLOWING_ERROR_FLAG)
    else $error("following error not flagged");
  chk_cam_clear: assert property (I_POSITION_ACTUAL > I_CAM_POSITION_ONE |=> !O_CAM_FLAG_ONE)
    else $error("cam flag one not cleared");
  chk_start_edge: assert property ($rose(O_ENC_CTRL_REF_SEARCH) |-> $past(rise_ref))
    else $error("search started without rising edge");
  chk_hold_value: assert property (O_MEASURED_VALUE_VALID && $past(O_MEASURED_VALUE_VALID)
                                   |-> $stable(O_MEASURED_VALUE))
    else $error("measured value changed while valid");
  chk_abort_drop: assert property (running && !run_req
                                   |=> !O_ENC_CTRL_REF_SEARCH && !O_ENC_CTRL_PROBE_EVAL)
    else $error("function not aborted on request drop");
  chk_conflict_alarm: assert property (both_req |=> O_REF_FUNCTION_ABORT_ALARM
                                       && !O_ENC_CTRL_REF_SEARCH && !O_ENC_CTRL_PROBE_EVAL)
    else $error("conflicting requests not blocked");
  chk_fault_latch: assert property (O_POSITIONING_FAULT && !I_FAULT_ACK |=> O_POSITIONING_FAULT)
    else $error("positioning fault dropped without acknowledge");

  cov_search_done: cover property (O_ENC_CTRL_REF_SEARCH ##[1:50] O_MEASURED_VALUE_VALID);
  cov_probe_start: cover property ($rose(O_ENC_CTRL_PROBE_EVAL));
  cov_conflict: cover property ($rose(O_REF_FUNCTION_ABORT_ALARM));
  cov_pos_fault: cover property ($rose(O_POSITIONING_FAULT));
endmodule : pmrh_top
`default_nettype wire

//--- pmrh_enc_model.sv
// encoder evaluation model answering the reference and probe control word
`timescale 1ns/1ps
`default_nettype none
module pmrh_enc_model
  import pmrh_pkg::*;
#(
  parameter logic [PMRH_POS_W-1:0] P_MEAS = 32'h00001230
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control word from the block
  input wire logic i_ctrl_ref_search,
  input wire logic i_ctrl_probe_eval,
  input wire logic i_probe_sel,
  input wire logic i_probe_edge,
  // scenario controls
  input wire logic i_slow,
  input wire logic i_fault_inject,
  // status word to the block
  output logic o_func_active,
  output logic o_value_valid,
  output logic o_fault,
  output logic signed [PMRH_POS_W-1:0] o_measured
);
  logic [7:0] cnt;
  logic [PMRH_POS_W-1:0] noise;
  wire logic run = i_ctrl_ref_search | i_ctrl_probe_eval;
  wire logic [7:0] lat = i_slow ? 8'h0C : 8'h03;
  wire logic [PMRH_POS_W-1:0] probe_ofs = {30'h0, i_probe_sel, i_probe_edge};
  // active while requested, dropped on abort
  always_ff @(posedge i_clk) begin
    noise <= !i_rstn ? 32'h5A5A5A5A : ~noise + 32'h00000013;
    if (!i_rstn || !run) begin
      cnt <= 8'h00;
      o_func_active <= 1'b0;
      o_value_valid <= 1'b0;
    end else begin
      o_func_active <= 1'b1;
      if (cnt < lat) begin
        cnt <= cnt + 8'h01;
      end else begin
        o_value_valid <= 1'b1;
      end
    end
  end
  assign o_fault = i_fault_inject & o_func_active;
  // value meaningless unless valid, so it keeps changing
  assign o_measured = o_value_valid ? P_MEAS + (i_ctrl_probe_eval ? probe_ofs : 32'h0) : noise;
endmodule : pmrh_enc_model
`default_nettype wire

//--- tb.sv
// self-checking testbench for the position monitor and reference handshake
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
`define WAITF(c, n) begin k = 0; while ((c) !== 1'b1 && k < (n)) begin @(negedge clk); k++; end \
  if ((c) !== 1'b1) begin num_errors++; $display("BAD wait expected 1 seen 0"); stop_test(); end end
module tb;
  import pmrh_pkg::*;
  localparam logic [31:0] MEAS = 32'h00001230;
  logic clk = 0, rstn = 0, sp_static = 0, trav = 0, ack = 0, req_s = 0, req_p = 0;
  logic p_sel = 0, p_edge = 0, inj = 0, slow = 0;
  logic [31:0] ss_win = 0, ps_win = 0, fe_tol = 0;
  logic [15:0] ss_time = 0, ps_time = 0;
  logic signed [31:0] cam1 = 0, cam2 = 0, pos_err = 0, fe_val = 0, pos_act = 0;
  logic ss_f, ps_f, fe_f, no_fe, cf1, cf2, c_rs, c_pe, c_sel, c_edge, r_act, m_valid, alarm;
  logic e_act, e_valid, e_fault;
  logic signed [31:0] m_val, e_meas;
  int num_errors = 0, samples_checked = 0, k;
  pmrh_top #(.P_TICK_CYCLES(4)) pmrh_top_inst (.I_REF_CLK(clk), .I_RSTN(rstn),
    .I_STANDSTILL_WINDOW(ss_win), .I_STANDSTILL_TIME(ss_time), .I_POSITIONING_WINDOW(ps_win),
    .I_POSITIONING_TIME(ps_time), .I_FOLLOWING_ERROR_TOLERANCE(fe_tol),
    .I_CAM_POSITION_ONE(cam1), .I_CAM_POSITION_TWO(cam2), .I_SETPOINT_STATIC(sp_static),
    .I_TRAVERSE_CMD_ACTIVE(trav), .I_POSITION_ERROR(pos_err), .I_FOLLOWING_ERROR_VALUE(fe_val),
    .I_POSITION_ACTUAL(pos_act), .I_FAULT_ACK(ack), .O_STANDSTILL_FAULT(ss_f),
    .O_POSITIONING_FAULT(ps_f), .O_FOLLOWING_ERROR_FAULT(fe_f), .O_NO_FOLLOWING_ERROR_FLAG(no_fe),
    .O_CAM_FLAG_ONE(cf1), .O_CAM_FLAG_TWO(cf2), .I_REF_MARK_SEARCH_REQ(req_s),
    .I_PROBE_EVAL_REQ(req_p), .I_PROBE_SELECT(p_sel), .I_PROBE_EDGE_SELECT(p_edge),
    .I_ENC_STAT_FUNC_ACTIVE(e_act), .I_ENC_STAT_VALUE_VALID(e_valid), .I_ENC_STAT_FAULT(e_fault),
    .I_ENC_MEASURED(e_meas), .O_ENC_CTRL_REF_SEARCH(c_rs), .O_ENC_CTRL_PROBE_EVAL(c_pe),
    .O_ENC_CTRL_PROBE_SEL(c_sel), .O_ENC_CTRL_PROBE_EDGE(c_edge), .O_REF_FUNCTION_ACTIVE(r_act),
    .O_MEASURED_VALUE_VALID(m_valid), .O_MEASURED_VALUE(m_val),
    .O_REF_FUNCTION_ABORT_ALARM(alarm));
  pmrh_enc_model #(.P_MEAS(MEAS)) pmrh_enc_model_inst (.i_clk(clk), .i_rstn(rstn),
    .i_ctrl_ref_search(c_rs), .i_ctrl_probe_eval(c_pe), .i_probe_sel(c_sel),
    .i_probe_edge(c_edge), .i_slow(slow), .i_fault_inject(inj), .o_func_active(e_act),
    .o_value_valid(e_valid), .o_fault(e_fault), .o_measured(e_meas));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse_ack;
    ack = 1;
    cyc(1);
    ack = 0;
    cyc(1);
  endtask : pulse_ack
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic t_cam;
    cam1 = 100;
    cam2 = -50;
    pos_act = 100;
    cyc(2);
    `CHK("cam one at", 1'b1, cf1)
    `CHK("cam two above", 1'b0, cf2)
    pos_act = 101;
    cyc(2);
    `CHK("cam one past", 1'b0, cf1)
    pos_act = -50;
    cyc(2);
    `CHK("cam two at", 1'b1, cf2)
    pos_act = -49;
    cyc(2);
    `CHK("cam two past", 1'b0, cf2)
    $display("test cam done");
  endtask : t_cam
  task automatic t_follow;
    fe_tol = 100;
    fe_val = -100;
    cyc(2);
    `CHK("fe at tol", 1'b0, fe_f)
    fe_val = -101;
    cyc(2);
    `CHK("fe fault", 1'b1, fe_f)
    `CHK("no fe flag", 1'b0, no_fe)
    fe_val = 0;
    cyc(2);
    `CHK("fe latched", 1'b1, fe_f)
    `CHK("no fe back", 1'b1, no_fe)
    pulse_ack();
    `CHK("fe acked", 1'b0, fe_f)
    fe_val = 500;
    cyc(2);
    rstn = 0;
    fe_val = 0;
    cyc(2);
    `CHK("fe reset", 1'b0, fe_f)
    `CHK("no fe reset", 1'b1, no_fe)
    rstn = 1;
    fe_tol = 32'h00000000;
    fe_val = 32'h000001F4;
    cyc(2);
    `CHK("fe disabled", 1'b0, fe_f)
    `CHK("no fe disabled", 1'b1, no_fe)
    fe_val = 32'h00000000;
    $display("test follow done");
  endtask : t_follow
  task automatic t_standstill;
    ss_win = 10; // standstill window above positioning window, same time
    ss_time = 2;
    ps_time = 2;
    pos_err = -20;
    sp_static = 1;
    trav = 1;
    cyc(4);
    `CHK("ss early", 1'b0, ss_f)
    `WAITF(ss_f, 12)
    pos_err = 5;
    pulse_ack();
    cyc(3);
    `CHK("ss inside", 1'b0, ss_f)
    ss_win = 0;
    pos_err = -20;
    cyc(20);
    `CHK("ss disabled", 1'b0, ss_f)
    sp_static = 0;
    $display("test standstill done");
  endtask : t_standstill
  task automatic t_positioning;
    ps_win = 5;
    ps_time = 1;
    pos_err = 20;
    sp_static = 1;
    cyc(20);
    `CHK("ps traverse", 1'b0, ps_f)
    pos_err = 0;
    trav = 0;
    cyc(15);
    pos_err = 20;
    cyc(15);
    `CHK("ps once", 1'b0, ps_f)
    trav = 1;
    cyc(2);
    trav = 0;
    `WAITF(ps_f, 12)
    trav = 1;
    pulse_ack();
    ps_win = 0;
    trav = 0;
    cyc(15);
    `CHK("ps disabled", 1'b0, ps_f)
    sp_static = 0;
    trav = 1;
    $display("test positioning done");
  endtask : t_positioning
  task automatic t_search;
    slow = 1;
    req_s = 1;
    `WAITF(c_rs, 3)
    `WAITF(m_valid, 30)
    `CHK("active", 1'b1, r_act)
    `CHK("value", MEAS, m_val)
    cyc(10);
    `CHK("valid hold", 1'b1, m_valid)
    `CHK("active hold", 1'b1, r_act)
    `CHK("value hold", MEAS, m_val)
    req_s = 0; // requester releases only after reading the value
    cyc(2);
    `CHK("ctrl drop", 1'b0, c_rs)
    `CHK("valid drop", 1'b0, m_valid)
    `WAITF(!r_act, 4)
    $display("test search done");
  endtask : t_search
  task automatic t_probe;
    for (int i = 0; i < 4; i++) begin
      p_sel = i[1];
      p_edge = i[0];
      slow = i[0];
      req_p = 1;
      `WAITF(c_pe, 3)
      `CHK("probe sel", p_sel, c_sel)
      `CHK("probe edge", p_edge, c_edge)
      `WAITF(m_valid, 30)
      `CHK("probe value", MEAS + 32'(i), m_val)
      req_p = 0;
      cyc(3);
    end
    slow = 1;
    req_p = 1;
    `WAITF(r_act, 5)
    req_p = 0;
    cyc(2);
    `CHK("abort ctrl", 1'b0, c_pe)
    `CHK("abort valid", 1'b0, m_valid)
    `WAITF(!r_act, 4)
    $display("test probe done");
  endtask : t_probe
  task automatic t_alarm;
    req_s = 1;
    `WAITF(r_act, 5)
    req_p = 1;
    cyc(2);
    `CHK("both ctrl s", 1'b0, c_rs)
    `CHK("both ctrl p", 1'b0, c_pe)
    `CHK("both alarm", 1'b1, alarm)
    req_s = 0;
    cyc(3);
    `CHK("alarm held", 1'b1, alarm)
    `CHK("no restart", 1'b0, c_pe)
    req_p = 0;
    cyc(2);
    `CHK("alarm clear", 1'b0, alarm)
    req_s = 1;
    `WAITF(r_act, 5)
    inj = 1;
    cyc(2);
    `CHK("enc fault alarm", 1'b1, alarm)
    `CHK("enc fault ctrl", 1'b0, c_rs)
    inj = 0;
    cyc(2);
    `CHK("enc alarm held", 1'b1, alarm)
    req_s = 0;
    cyc(2);
    `CHK("enc alarm clear", 1'b0, alarm)
    $display("test alarm done");
  endtask : t_alarm
  initial begin
    cyc(4);
    `CHK("rst ctrl", 4'h0, {c_rs, c_pe, c_sel, c_edge})
    `CHK("rst no fe", 1'b1, no_fe)
    rstn = 1;
    cyc(1);
    t_cam();
    t_follow();
    t_standstill();
    t_positioning();
    t_search();
    t_probe();
    t_alarm();
    stop_test();
  end
endmodule : tb
`default_nettype wire
